// file: design/supply_sequencing_state_engine.sv
// power sequencing state engine with output source and drive selection
`timescale 1ns/1ns
module supply_sequencing_state_engine
  import seq_engine_pkg::*;
#(
  parameter int WARN_W = 10
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic supply_above_1v2_in,
  input wire logic supply_above_2v7_in,
  input wire logic [NUM_IN-1:0] detector_status_in,
  input wire logic [WARN_W-1:0] limit_warn_in,
  input wire logic [4:0] secondary_warn_in,
  output logic [NUM_OUT-1:0] drive_level_out,
  output logic [NUM_OUT-1:0] drive_oe_out,
  output logic [NUM_OUT-1:0] drive_weak_pd_out,
  output logic [NUM_OUT*MODE_W-1:0] drive_mode_out,
  output logic [STATE_W-1:0] state_out
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] state_mem [0:MEM_DEPTH-1];
  logic [MEM_DEPTH-1:0] written_r;
  logic programmed_r;
  logic jump_pend_r;
  logic [NUM_OUT-1:0] host_out_r;
  logic [NUM_OUT*SRC_W-1:0] src_cfg_r;
  logic [NUM_OUT*MODE_W-1:0] mode_cfg_r;
  logic [VEC_W-1:0] fault_r;
  phase_e phase_r;
  logic [STATE_W-1:0] cur_state_r;
  logic [1:0] ld_cnt_r;
  logic [DATA_W-1:0] def_r [0:WORDS_PER_STATE-1];
  logic [15:0] div_cnt_r;
  logic clk100k_r;
  logic [DELAY_W-1:0] seq_cnt_r;
  logic [DELAY_W-1:0] tmo_cnt_r;
  logic seq_prev_r;

  function automatic logic [ADDR_W-1:0] mem_index(
    input logic [STATE_W-1:0] st, input logic [1:0] w);
    mem_index = {2'h0, st, w};
  endfunction

  function automatic logic [DATA_W-1:0] mem_word(input logic [ADDR_W-1:0] a);
    mem_word = written_r[a[7:0]] ? state_mem[a[7:0]] : '0;
  endfunction

  // ----------------------------------------------------------------
  // decoded state definition
  // ----------------------------------------------------------------
  logic warn;
  logic [VEC_W-1:0] in_vec;
  logic [STATE_W-1:0] seq_tgt, mon_tgt, tmo_tgt;
  logic [W1_SEL_W-1:0] seq_sel;
  logic seq_bit, seq_cond, seq_fire, tmo_fire, mon_fire, jump_go;
  logic [VEC_W-1:0] mon_mask, mon_expect, deviation;
  logic [DELAY_W-1:0] seq_dly, tmo_dly;
  logic is_run, tick;
  logic ctrl_wr, fault_wr;

  assign warn = (|limit_warn_in) | (|secondary_warn_in);
  // detector inputs arrive already filtered; no raw pin is looked at
  assign in_vec = {warn, detector_status_in};
  assign seq_tgt = def_r[1][W1_SEQ_TGT_LSB +: STATE_W];
  assign mon_tgt = def_r[1][W1_MON_TGT_LSB +: STATE_W];
  assign tmo_tgt = def_r[1][W1_TMO_TGT_LSB +: STATE_W];
  assign seq_sel = def_r[1][W1_SEL_LSB +: W1_SEL_W];
  assign seq_bit = (seq_sel < W1_SEL_W'(VEC_W)) ? in_vec[seq_sel] : 1'b0;
  assign seq_cond = seq_bit == def_r[1][W1_POL_BIT];
  assign mon_mask = def_r[2][W2_MASK_LSB +: VEC_W];
  assign mon_expect = def_r[2][W2_EXPECT_LSB +: VEC_W];
  assign seq_dly = def_r[3][W3_SEQ_DLY_LSB +: DELAY_W];
  assign tmo_dly = def_r[3][W3_TMO_DLY_LSB +: DELAY_W];
  assign deviation = (in_vec ^ mon_expect) & mon_mask;
  assign is_run = phase_r == PH_RUN;

  assign seq_fire = def_r[0][W0_SEQ_EN_BIT] && seq_cond &&
                    seq_cnt_r >= seq_dly;
  assign tmo_fire = def_r[0][W0_TMO_EN_BIT] && !seq_cond &&
                    tmo_cnt_r >= tmo_dly;
  assign mon_fire = def_r[0][W0_MON_EN_BIT] && (|deviation);
  assign jump_go = jump_pend_r;

  assign ctrl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
  assign fault_wr = reg_wr_in && reg_addr_in == REG_FAULT;

  // ----------------------------------------------------------------
  // clock divider: 100 kHz output clock and 10 us timer tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_r <= '0;
      clk100k_r <= 1'b0;
    end else if (div_cnt_r == 16'(HALF_CYCLES - 1)) begin
      div_cnt_r <= '0;
      clk100k_r <= ~clk100k_r;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // one tick per full period of the output clock
  assign tick = clk100k_r && div_cnt_r == 16'(HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reg_wr_in && reg_addr_in < STATE_MEM_END) begin
      state_mem[reg_addr_in[7:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      written_r <= '0;
      programmed_r <= 1'b0;
      host_out_r <= '0;
      src_cfg_r <= '0;
      mode_cfg_r <= '0;
    end else if (reg_wr_in) begin
      if (reg_addr_in < STATE_MEM_END) begin
        written_r[reg_addr_in[7:0]] <= 1'b1;
      end else if (reg_addr_in == REG_CTRL) begin
        programmed_r <= reg_wdata_in[CTRL_PROG_BIT];
      end else if (reg_addr_in == REG_HOST_OUT) begin
        host_out_r <= reg_wdata_in[NUM_OUT-1:0];
      end else if (reg_addr_in == REG_SRC_CFG) begin
        src_cfg_r <= reg_wdata_in[NUM_OUT*SRC_W-1:0];
      end else if (reg_addr_in == REG_MODE_CFG) begin
        mode_cfg_r <= reg_wdata_in[NUM_OUT*MODE_W-1:0];
      end
    end
  end

  // jump request waits for the engine to be running; set beats clear
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      jump_pend_r <= 1'b0;
    end else if (ctrl_wr && reg_wdata_in[CTRL_JUMP_BIT]) begin
      jump_pend_r <= 1'b1;
    end else if (is_run && !mon_fire && !tmo_fire) begin
      jump_pend_r <= 1'b0;
    end else if (phase_r == PH_OFF) begin
      jump_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencing phase and state transitions
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_r <= PH_OFF;
      cur_state_r <= '0;
      ld_cnt_r <= '0;
    end else if (!supply_above_1v2_in) begin
      phase_r <= PH_OFF;
    end else if (!supply_above_2v7_in || !programmed_r) begin
      phase_r <= PH_WAIT;
      cur_state_r <= '0;
    end else begin
      case (phase_r)
        PH_OFF, PH_WAIT: begin
          phase_r <= PH_LOAD;
          ld_cnt_r <= '0;
        end
        PH_LOAD: begin
          ld_cnt_r <= ld_cnt_r + 2'h1;
          if (ld_cnt_r == 2'(WORDS_PER_STATE - 1)) begin
            phase_r <= PH_RUN;
          end
        end
        PH_RUN: begin
          // fault first, then timeout, then sequence or jump
          if (mon_fire) begin
            cur_state_r <= mon_tgt;
            phase_r <= PH_LOAD;
          end else if (tmo_fire) begin
            cur_state_r <= tmo_tgt;
            phase_r <= PH_LOAD;
          end else if (seq_fire || jump_go) begin
            cur_state_r <= seq_tgt;
            phase_r <= PH_LOAD;
          end
          ld_cnt_r <= '0;
        end
        default: phase_r <= PH_OFF;
      endcase
    end
  end

  // definition is copied word by word; writes to the table never
  // disturb the state that is already running
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < WORDS_PER_STATE; i++) begin
        def_r[i] <= '0;
      end
    end else if (phase_r == PH_LOAD) begin
      def_r[ld_cnt_r] <= mem_word(mem_index(cur_state_r, ld_cnt_r));
    end else if (phase_r != PH_RUN) begin
      for (int i = 0; i < WORDS_PER_STATE; i++) begin
        def_r[i] <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // delay timers, restarted on every state entry
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seq_cnt_r <= '0;
      tmo_cnt_r <= '0;
      seq_prev_r <= 1'b0;
    end else begin
      seq_prev_r <= seq_bit;
      if (!is_run) begin
        seq_cnt_r <= '0;
        tmo_cnt_r <= '0;
      end else begin
        if (seq_bit != seq_prev_r || !seq_cond) begin
          seq_cnt_r <= '0;
        end else if (tick && seq_cnt_r != '1) begin
          seq_cnt_r <= seq_cnt_r + 16'h0001;
        end
        if (tick && tmo_cnt_r != '1) begin
          tmo_cnt_r <= tmo_cnt_r + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fault record, write one to clear, a new fault wins over the clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_r <= '0;
    end else begin
      fault_r <= (fault_r & ~(fault_wr ? reg_wdata_in[VEC_W-1:0] : '0)) |
                 ((is_run && def_r[0][W0_LATCH_BIT]) ? deviation : '0);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= '0;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= '0;
    end else if (reg_addr_in < STATE_MEM_END) begin
      reg_rdata_out <= mem_word(reg_addr_in);
    end else if (reg_addr_in == REG_CTRL) begin
      reg_rdata_out <= DATA_W'(programmed_r);
    end else if (reg_addr_in == REG_HOST_OUT) begin
      reg_rdata_out <= DATA_W'(host_out_r);
    end else if (reg_addr_in == REG_SRC_CFG) begin
      reg_rdata_out <= DATA_W'(src_cfg_r);
    end else if (reg_addr_in == REG_MODE_CFG) begin
      reg_rdata_out <= DATA_W'(mode_cfg_r);
    end else if (reg_addr_in == REG_STATUS) begin
      reg_rdata_out <= DATA_W'({jump_pend_r, warn, 2'h0, 2'(phase_r),
                               2'h0, cur_state_r});
    end else if (reg_addr_in == REG_FAULT) begin
      reg_rdata_out <= DATA_W'(fault_r);
    end else if (reg_addr_in == REG_INPUTS) begin
      reg_rdata_out <= DATA_W'(in_vec);
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_level_out <= '0;
      drive_oe_out <= '0;
      drive_weak_pd_out <= '0;
      drive_mode_out <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        logic lvl;
        logic [MODE_W-1:0] md;
        lvl = 1'b0;
        md = mode_cfg_r[i*MODE_W +: MODE_W];
        case (src_cfg_r[i*SRC_W +: SRC_W])
          SRC_HOST: lvl = host_out_r[i];
          SRC_CLOCK: lvl = clk100k_r;
          default: lvl = def_r[0][i];
        endcase
        // charge pump exists on the first outputs only
        if (md == MODE_CHARGE_PUMP && i >= CP_OUTPUTS) begin
          md = MODE_OD;
        end
        if (!is_run) begin
          md = MODE_WEAK_PD;
        end
        drive_level_out[i] <= lvl;
        drive_mode_out[i*MODE_W +: MODE_W] <= md;
        // the supply input is looked at directly so that a collapse takes
        // the pins high impedance at once, not one phase later
        if (phase_r == PH_OFF || !supply_above_1v2_in) begin
          drive_oe_out[i] <= 1'b0;
          drive_weak_pd_out[i] <= 1'b0;
        end else if (md == MODE_WEAK_PD) begin
          drive_oe_out[i] <= 1'b0;
          drive_weak_pd_out[i] <= 1'b1;
        end else if (md == MODE_STRONG_PD || md == MODE_CHARGE_PUMP) begin
          drive_oe_out[i] <= 1'b1;
          drive_weak_pd_out[i] <= 1'b0;
        end else begin
          drive_oe_out[i] <= ~lvl;
          drive_weak_pd_out[i] <= 1'b0;
        end
      end
    end
  end

  assign state_out = cur_state_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence load_start_s;
    $rose(phase_r == PH_LOAD);
  endsequence
  sequence supply_held_s;
    (supply_above_2v7_in && supply_above_1v2_in && programmed_r)[*3];
  endsequence

  load_finishes_a: assert property (
    load_start_s ##1 supply_held_s |=> phase_r == PH_RUN)
    else $error("state load did not finish in four cycles");
  fault_first_a: assert property (
    is_run && mon_fire && supply_above_2v7_in && programmed_r
    |=> phase_r == PH_LOAD && cur_state_r == $past(mon_tgt))
    else $error("fault exit not taken at once");
  timeout_next_a: assert property (
    is_run && !mon_fire && tmo_fire && supply_above_2v7_in && programmed_r
    |=> cur_state_r == $past(tmo_tgt))
    else $error("timeout exit not taken");
  sequence_exit_a: assert property (
    is_run && !mon_fire && !tmo_fire && (seq_fire || jump_pend_r) &&
    supply_above_2v7_in && programmed_r
    |=> phase_r == PH_LOAD && cur_state_r == $past(seq_tgt) && !jump_pend_r)
    else $error("sequence or jump exit not taken");
  levels_held_a: assert property (
    is_run && $past(is_run) |-> def_r[0] == $past(def_r[0]))
    else $error("output levels changed inside a state");
  off_highz_a: assert property (
    !supply_above_1v2_in |=> drive_oe_out == '0 && drive_weak_pd_out == '0)
    else $error("outputs driven below 1.2 V");
  unprog_weak_a: assert property (
    !programmed_r && supply_above_1v2_in ##1 supply_above_1v2_in |=>
    drive_weak_pd_out == '1 && drive_oe_out == '0)
    else $error("unprogrammed outputs not weakly low");
  fault_latch_a: assert property (
    is_run && def_r[0][W0_LATCH_BIT] |=> (fault_r & $past(deviation))
    == $past(deviation))
    else $error("fault not latched");
  seq_restart_a: assert property (
    is_run && seq_bit != seq_prev_r |=> seq_cnt_r == '0)
    else $error("sequence delay not restarted");

  logic [11:0] load_len_r;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      load_len_r <= '0;
    end else begin
      load_len_r <= (phase_r == PH_LOAD) ? load_len_r + 12'h001 : '0;
    end
  end
  load_bound_a: assert property (
    load_len_r < 12'(LOAD_MAX_CYCLES))
    else $error("state transition took over 20 us");

endmodule

// file: design/seq_engine_pkg.sv
// constants, register map and state-definition layout of the sequencing engine
// Functional notes
// - up to 63 independently defined states
// - every state watches all ten inputs
// - any state may target any state
// - three exits: sequence, fault, timeout
// - per-state sequence and timeout delays, 0-400 ms
// - ten output levels fixed per state
// - state transition finishes under 20 us
// - warnings ORed into one exit input
// - host jump forces unconditional advance
// - per-output source: engine, host or clock
// - internal 100 kHz clock routable to outputs
// - selectable drive modes, charge pump 1-6
// - unprogrammed device keeps outputs weakly low
// - high-z below 1.2 V, then weak low
// - above 2.7 V load, latch, then drive
// - exits use filtered detector outputs
// - timeout fires when awaited condition missing
// - input change restarts the sequence delay
// - fault exit reacts with no delay
// - fault latching enabled per state
package seq_engine_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 10;
  localparam int NUM_IN = 10;
  localparam int VEC_W = NUM_IN + 1;
  localparam int NUM_STATES = 63;
  localparam int WORDS_PER_STATE = 4;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int MEM_DEPTH = 256;
  localparam int STATE_W = 6;
  localparam int DELAY_W = 16;
  localparam int SRC_W = 2;
  localparam int MODE_W = 3;
  localparam int CP_OUTPUTS = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int OUT_CLK_HZ = 100000;
  localparam int SYS_HZ = 1000000000 / CLK_NS;
  localparam int HALF_CYCLES = SYS_HZ / (2 * OUT_CLK_HZ);
  localparam int TICK_US = 10;
  localparam int STATE_LOAD_NS = 20000;
  localparam int LOAD_MAX_CYCLES = STATE_LOAD_NS / CLK_NS;
  localparam int MAX_DELAY_MS = 400;
  localparam int MAX_DELAY_TICKS = MAX_DELAY_MS * 1000 / TICK_US;

  // ----------------------------------------------------------------
  // register indices (the address is a word index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STATE_MEM_END = 10'h0fc;
  localparam logic [ADDR_W-1:0] REG_CTRL = 10'h100;
  localparam logic [ADDR_W-1:0] REG_HOST_OUT = 10'h101;
  localparam logic [ADDR_W-1:0] REG_SRC_CFG = 10'h102;
  localparam logic [ADDR_W-1:0] REG_MODE_CFG = 10'h103;
  localparam logic [ADDR_W-1:0] REG_STATUS = 10'h104;
  localparam logic [ADDR_W-1:0] REG_FAULT = 10'h105;
  localparam logic [ADDR_W-1:0] REG_INPUTS = 10'h106;

  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_JUMP_BIT = 1;
  localparam int STAT_PHASE_LSB = 8;
  localparam int STAT_WARN_BIT = 12;
  localparam int STAT_JUMP_BIT = 13;

  // ----------------------------------------------------------------
  // state definition word fields
  // ----------------------------------------------------------------
  localparam int W0_LATCH_BIT = 16;
  localparam int W0_TMO_EN_BIT = 17;
  localparam int W0_SEQ_EN_BIT = 18;
  localparam int W0_MON_EN_BIT = 19;
  localparam int W1_SEQ_TGT_LSB = 0;
  localparam int W1_MON_TGT_LSB = 8;
  localparam int W1_TMO_TGT_LSB = 16;
  localparam int W1_SEL_LSB = 24;
  localparam int W1_SEL_W = 4;
  localparam int W1_POL_BIT = 28;
  localparam int W2_MASK_LSB = 0;
  localparam int W2_EXPECT_LSB = 16;
  localparam int W3_SEQ_DLY_LSB = 0;
  localparam int W3_TMO_DLY_LSB = 16;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_ENGINE = 2'h0;
  localparam logic [SRC_W-1:0] SRC_HOST = 2'h1;
  localparam logic [SRC_W-1:0] SRC_CLOCK = 2'h2;

  localparam logic [MODE_W-1:0] MODE_WEAK_PD = 3'h0;
  localparam logic [MODE_W-1:0] MODE_OD = 3'h1;
  localparam logic [MODE_W-1:0] MODE_OD_WEAK_VDD = 3'h2;
  localparam logic [MODE_W-1:0] MODE_OD_STRONG_VDD = 3'h3;
  localparam logic [MODE_W-1:0] MODE_OD_WEAK_VP = 3'h4;
  localparam logic [MODE_W-1:0] MODE_OD_STRONG_VP = 3'h5;
  localparam logic [MODE_W-1:0] MODE_STRONG_PD = 3'h6;
  localparam logic [MODE_W-1:0] MODE_CHARGE_PUMP = 3'h7;

  typedef enum logic [1:0] {PH_OFF, PH_WAIT, PH_LOAD, PH_RUN} phase_e;

endpackage

// file: bench/supply_model.sv
// far-side model: one regulator switched by drive output 0
`timescale 1ns/1ns
module supply_model (
  input wire logic clk_sys_in,
  input wire logic enable_in,
  input wire logic drop_in,
  input wire logic [9:0] sense_in,
  output logic [9:0] status_out
);
  int ramp = 0;
  // the rail needs a ramp before its detector reports good
  always @(posedge clk_sys_in) begin
    if (!enable_in)
      ramp <= 0;
    else if (ramp < 20)
      ramp <= ramp + 1;
  end
  // filtered detector levels; drop_in is a brief dip of the rail
  assign status_out = {sense_in[9:2], ramp == 20 && !drop_in, sense_in[0]};
endmodule

// file: bench/testbench.sv
// self-checking bench for the supply sequencing state engine
`timescale 1ns/1ns
module testbench;
  import seq_engine_pkg::*;
  logic clk_sys_in = 0;
  logic reset_n_in = 0;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0;
  logic reg_wr_in = 0;
  logic reg_rd_in = 0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic supply_1v2 = 0;
  logic supply_2v7 = 0;
  logic drop = 0;
  logic [NUM_IN-1:0] tb_status = '1;
  logic [NUM_IN-1:0] det;
  logic [9:0] lim_warn = '0;
  logic [4:0] sec_warn = '0;
  logic [NUM_OUT-1:0] lvl, oe, wpd;
  logic [NUM_OUT*MODE_W-1:0] mode;
  logic [STATE_W-1:0] st;
  logic [31:0] d;
  int failures = 0;
  int checks_done = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  supply_sequencing_state_engine u_supply_sequencing_state_engine (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .supply_above_1v2_in(supply_1v2),
    .supply_above_2v7_in(supply_2v7), .detector_status_in(det),
    .limit_warn_in(lim_warn), .secondary_warn_in(sec_warn),
    .drive_level_out(lvl), .drive_oe_out(oe), .drive_weak_pd_out(wpd),
    .drive_mode_out(mode), .state_out(st));

  supply_model u_supply_model (.clk_sys_in(clk_sys_in),
    .enable_in(lvl[0]), .drop_in(drop), .sense_in(tb_status),
    .status_out(det));

  // ----
  // shared tasks
  // ----
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic wr(logic [9:0] a, logic [31:0] v);
    tick(1);
    reg_wr_in <= 1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    tick(1);
    reg_wr_in <= 0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [9:0] a);
    tick(1);
    reg_rd_in <= 1;
    reg_addr_in <= a;
    tick(1);
    reg_rd_in <= 0;
    #1;
    d = reg_rdata_out;
  endtask

  task automatic defst(int s, logic [31:0] w0, w1, w2, w3);
    wr(10'(s * 4), w0);
    wr(10'(s * 4 + 1), w1);
    wr(10'(s * 4 + 2), w2);
    wr(10'(s * 4 + 3), w3);
  endtask

  // bounded wait for a state, then let load and output lag pass
  task automatic wait_st(logic [5:0] s, int lim);
    int n;
    n = 0;
    while (st !== s && n < lim) begin
      tick(1);
      n++;
    end
    check("state", st, s);
    tick(7);
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic power_up;
    tick(12);
    reset_n_in <= 1;
    tick(3);
    #1;
    check("oe_off", oe, 0);
    check("wpd_off", wpd, 0);
    tick(1);
    supply_1v2 <= 1;
    tick(4);
    #1;
    check("wpd_wait", wpd, 10'h3ff);
    check("oe_wait", oe, 0);
    defst(0, 32'h0004_0005, 32'h1100_0005, 0, 32'h0000_0003);
    defst(5, 32'h000b_03f0, 32'h0307_2800, 32'h0004_0004, 0);
    defst(40, 32'h0002_0200, 32'h0407_0000, 0, 32'h0003_0000);
    defst(7, 32'h0008_0001, 32'h0000_0900, 32'h0000_0400, 0);
    defst(9, 32'h0004_0000, 32'h0300_000b, 0, 0);
    defst(11, 32'h0008_0000, 32'h0000_0d00, 32'h0000_0400, 0);
    rd(10'h1ff);
    check("unmapped", d, 0);
    wr(REG_CTRL, 32'h0000_0001);
    tb_status[2] <= 1'b0;
    supply_2v7 <= 1;
    tick(12);
    #1;
    check("run_state", st, 0);
    check("run_levels", lvl, 10'h005);
    $display("power_up done");
  endtask

  task automatic seq_exit;
    tick(1500);
    drop <= 1;
    tick(1);
    drop <= 0;
    tick(1700);
    #1;
    check("seq_hold", st, 0);
    wait_st(5, 2000);
    $display("seq_exit done");
  endtask

  // fault and zero-delay timeout both true on entry to state 5
  task automatic fault_first;
    wait_st(40, 100);
    check("fault_levels", lvl, 10'h200);
    rd(REG_FAULT);
    check("fault_rec", d, 32'h0000_0004);
    tick(1);
    tb_status[2] <= 1'b1;
    $display("fault_first done");
  endtask

  task automatic timeout_exit;
    tick(1500);
    #1;
    check("tmo_wait", st, 40);
    wait_st(7, 3000);
    check("tmo_levels", lvl, 10'h001);
    $display("timeout_exit done");
  endtask

  task automatic warn_and_jump;
    tick(1);
    sec_warn <= 5'h10;
    wait_st(9, 100);
    tick(1);
    sec_warn <= '0;
    wr(REG_CTRL, 32'h0000_0003);
    wait_st(11, 100);
    $display("warn_and_jump done");
  endtask

  task automatic sources_modes;
    int n;
    logic b;
    wr(REG_SRC_CFG, 32'h0000_0009);
    wr(REG_HOST_OUT, 32'h0000_0001);
    wr(REG_MODE_CFG, 32'h001c_0187);
    tick(3);
    #1;
    check("host_src", lvl[0], 1);
    check("engine_src", lvl[2], 0);
    check("pump_ok", mode[2:0], 3'h7);
    check("pump_refused", mode[20:18], 3'h1);
    check("strong_pd_oe", oe[2], 1);
    for (int k = 0; k < 2; k++) begin
      b = lvl[1];
      n = 0;
      while (lvl[1] === b && n < 1200) begin
        tick(1);
        #1;
        n++;
      end
    end
    check("clk_half", n, HALF_CYCLES);
    $display("sources_modes done");
  endtask

  task automatic limit_exit;
    tick(1);
    lim_warn <= 10'h200;
    wait_st(13, 100);
    check("empty_levels", lvl[9:2], 0);
    rd(REG_STATUS);
    check("status", d, 32'h0000_130d);
    $display("limit_exit done");
  endtask

  initial begin
    power_up();
    seq_exit();
    fault_first();
    timeout_exit();
    warn_and_jump();
    sources_modes();
    limit_exit();
    close_out();
  end

  // the run needs about 8000 cycles; two and a half times that means a hang
  initial begin
    tick(20000);
    failures++;
    close_out();
  end
endmodule
